// [design/cdr_lock_status_squelch.v]
// lock supervision, signal-loss flag and squelch output gating
//
// What this block does
// - error above 1000 ppm raises lock lost and starts a new acquisition.
// - each normal acquisition restarts oscillator tuning at the range bottom.
// - tuning steps coarse then finer; lock lost drops within 250 ppm.
// - falling lock lost turns off the frequency loop, phase loop proceeds.
// - signal-loss output is one when amplitude is below threshold.
// - signal-loss responds within about 500 ns of a level change.
// - signal-loss active high after reset, active low when polarity bit set.
// - signal-loss stays asserted until level reaches twice the threshold.
// - signal-loss uses absolute level, unaffected by slice offset.
// - lock-to-reference bit, range and ratio select reference comparison.
// - reference mode reacquires against reference on error above 1000 ppm.
// - any lock-lost event sets a sticky status bit that stays set.
// - writing one then zero to clear bit clears the sticky bit.
// - sticky select zero shows live lock lost, one shows sticky bit.
// - lower harmonic detected raises lock lost and restarts acquisition.
// - harmonic lock is detected within 16384 bit periods over density.
// - higher harmonics are left to the ordinary frequency-error path.
// - harmonic detection is disabled in reference lock mode.
// - squelch mode zero with squelch high zeroes clock and data.
// - squelch mode one: high silences data, low silences clock.
// - reference change needs lock bit zero-to-one; device relocks then.
`timescale 1ns/100ps
`include "cdr_lock_defs.vh"

module cdr_lock_status_squelch #(
  parameter ERR_W     = 16,
  parameter HARM_CNT  = `HARM_BIT_PERIODS,
  parameter LOSS_NS   = `LOSS_RESP_NS
) (
  // clock and reset
  input  wire             ref_clk_i,
  input  wire             srst_i,
  // register port
  input  wire [3:0]       addr_i,
  input  wire [7:0]       wdata_i,
  input  wire             wr_i,
  input  wire             rd_i,
  output reg  [7:0]       rdata_o,
  // analog measurement inputs (asynchronous)
  input  wire [ERR_W-1:0] data_ppm_err_i,
  input  wire [ERR_W-1:0] ref_ppm_err_i,
  input  wire             data_freq_above_i,
  input  wire             level_below_thr_i,
  input  wire             level_above_2thr_i,
  input  wire             lower_harmonic_i,
  input  wire             bit_tick_i,
  input  wire             squelch_i,
  // recovered outputs before gating
  input  wire             rec_clk_i,
  input  wire             rec_data_i,
  // loop control
  output reg  [15:0]      vco_tune_o,
  output reg              freq_loop_en_o,
  output reg              use_reference_o,
  output reg  [3:0]       ratio_o,
  output reg  [1:0]       range_o,
  // status pins and gated outputs
  output reg              lock_lost_flag_o,
  output reg              signal_loss_flag_o,
  output reg              recovered_clock_out_o,
  output reg              recovered_data_out_o
);

  localparam LOSS_CYC = (LOSS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam S_ACQ    = 2'b01;
  localparam S_LOCK   = 2'b10;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  wire [ERR_W-1:0] derr_s;
  wire [ERR_W-1:0] rerr_s;
  wire             above_s;
  wire             below_s;
  wire             above2_s;
  wire             harm_s;
  wire             tick_s;
  wire             squelch_s;

  sync_2ff #(
    .W (ERR_W)
  ) i_sync_derr (
    .clk_i (ref_clk_i),
    .d_i   (data_ppm_err_i),
    .q_o   (derr_s)
  );

  sync_2ff #(
    .W (ERR_W)
  ) i_sync_rerr (
    .clk_i (ref_clk_i),
    .d_i   (ref_ppm_err_i),
    .q_o   (rerr_s)
  );

  sync_2ff #(
    .W (1)
  ) i_sync_above (
    .clk_i (ref_clk_i),
    .d_i   (data_freq_above_i),
    .q_o   (above_s)
  );

  sync_2ff #(
    .W (1)
  ) i_sync_below (
    .clk_i (ref_clk_i),
    .d_i   (level_below_thr_i),
    .q_o   (below_s)
  );

  sync_2ff #(
    .W (1)
  ) i_sync_above2 (
    .clk_i (ref_clk_i),
    .d_i   (level_above_2thr_i),
    .q_o   (above2_s)
  );

  sync_2ff #(
    .W (1)
  ) i_sync_harm (
    .clk_i (ref_clk_i),
    .d_i   (lower_harmonic_i),
    .q_o   (harm_s)
  );

  sync_2ff #(
    .W (1)
  ) i_sync_tick (
    .clk_i (ref_clk_i),
    .d_i   (bit_tick_i),
    .q_o   (tick_s)
  );

  // squelch is retimed before it gates anything, so no runt pulses
  sync_2ff #(
    .W (1)
  ) i_sync_squelch (
    .clk_i (ref_clk_i),
    .d_i   (squelch_i),
    .q_o   (squelch_s)
  );

  // ****************************************************************
  // registers
  // ****************************************************************
  reg [7:0] ref_ctrl_ff;
  reg [7:0] lsc_ctrl_ff;
  reg [7:0] out_ctrl_ff;
  reg [1:0] state_ff;
  reg       sticky_ff;
  reg       lock_bit_q_ff;
  reg       clr_arm_ff;
  wire      ref_mode = ref_ctrl_ff[`REF_LOCK_BIT];
  wire      wr_ref   = wr_i && addr_i == `ADDR_REFERENCE_CONTROL;
  wire      wr_lsc   = wr_i && addr_i == `ADDR_LOCK_STATUS_CONTROL;
  wire      wr_out   = wr_i && addr_i == `ADDR_OUTPUT_CONTROL;

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      ref_ctrl_ff <= `RST_REFERENCE_CONTROL;
      lsc_ctrl_ff <= `RST_LOCK_STATUS_CONTROL;
      out_ctrl_ff <= `RST_OUTPUT_CONTROL;
      rdata_o     <= 8'h00;
    end else begin
      if (wr_ref)
        ref_ctrl_ff <= wdata_i;
      if (wr_lsc)
        lsc_ctrl_ff <= wdata_i;
      if (wr_out)
        out_ctrl_ff <= wdata_i;
      if (rd_i) begin
        case (addr_i)
          `ADDR_REFERENCE_CONTROL:   rdata_o <= ref_ctrl_ff;
          `ADDR_LOCK_STATUS_CONTROL: rdata_o <= lsc_ctrl_ff;
          `ADDR_OUTPUT_CONTROL:      rdata_o <= out_ctrl_ff;
          `ADDR_STATUS:              rdata_o <= {3'b000, sticky_ff, 1'b0,
                                       signal_loss_flag_o, 1'b0,
                                       state_ff == S_ACQ};
          default:                   rdata_o <= 8'h00;
        endcase
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end

  always @* begin
    use_reference_o = ref_mode;
    ratio_o         = ref_ctrl_ff[`REF_RATIO_MSB:`REF_RATIO_LSB];
    range_o         = ref_ctrl_ff[`REF_RANGE_MSB:`REF_RANGE_LSB];
  end

  // ****************************************************************
  // harmonic detector: condition must persist for HARM_CNT bit ticks
  // ****************************************************************
  reg [14:0] harm_cnt_ff;
  reg        tick_q_ff;
  reg        harm_hit_ff;
  wire       tick_edge = tick_s & ~tick_q_ff;

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      harm_cnt_ff <= 15'h0000;
      tick_q_ff   <= 1'b0;
      harm_hit_ff <= 1'b0;
    end else begin
      tick_q_ff   <= tick_s;
      harm_hit_ff <= 1'b0;
      // only lower harmonics, never in reference mode
      if (ref_mode || !harm_s || state_ff != S_LOCK) begin
        harm_cnt_ff <= 15'h0000;
      end else if (tick_edge) begin
        if (harm_cnt_ff == HARM_CNT[14:0] - 15'h0001) begin
          harm_cnt_ff <= 15'h0000;
          harm_hit_ff <= 1'b1;
        end else begin
          harm_cnt_ff <= harm_cnt_ff + 15'h0001;
        end
      end
    end
  end

  // ****************************************************************
  // frequency acquisition state machine
  // ****************************************************************
  wire [ERR_W-1:0] err = ref_mode ? rerr_s : derr_s;
  wire            err_big   = err > `PPM_LOCK_OUT;
  wire            err_small = err <= `PPM_LOCK_IN;
  wire            lock_rise = ref_mode & ~lock_bit_q_ff;
  reg  [15:0]     step;

  always @* begin
    if (err > 16'h4000)
      step = `TUNE_STEP_MAX;
    else if (err > 16'h0400)
      step = 16'h0040;
    else
      step = 16'h0001;
  end

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_ff       <= S_ACQ;
      vco_tune_o     <= `TUNE_BOTTOM;
      freq_loop_en_o <= 1'b1;
      lock_bit_q_ff  <= 1'b0;
    end else begin
      lock_bit_q_ff <= ref_mode;
      case (state_ff)
        S_ACQ: begin
          freq_loop_en_o <= 1'b1;
          if (lock_rise) begin
            vco_tune_o <= `TUNE_BOTTOM;
          end else if (err_small) begin
            state_ff       <= S_LOCK;
            freq_loop_en_o <= 1'b0;
          end else if (above_s) begin
            vco_tune_o <= vco_tune_o + step;
          end
        end
        S_LOCK: begin
          if (err_big || harm_hit_ff || lock_rise) begin
            state_ff       <= S_ACQ;
            freq_loop_en_o <= 1'b1;
            vco_tune_o     <= `TUNE_BOTTOM;
          end
        end
        default: begin
          state_ff <= S_ACQ;
        end
      endcase
    end
  end

  // ****************************************************************
  // sticky lock-lost bit and its one-then-zero clear
  // ****************************************************************
  wire lol_event = state_ff == S_ACQ;

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      sticky_ff  <= 1'b0;
      clr_arm_ff <= 1'b0;
    end else begin
      if (wr_lsc)
        clr_arm_ff <= wdata_i[`LSC_STICKY_CLR];
      if (lol_event)
        sticky_ff <= 1'b1;
      else if (wr_lsc && clr_arm_ff && !wdata_i[`LSC_STICKY_CLR])
        sticky_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // signal-loss detector with hysteresis and response delay
  // ****************************************************************
  reg [4:0] loss_cnt_ff;
  reg       loss_ff;
  wire      want = loss_ff ? !above2_s : below_s;

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      loss_ff     <= 1'b0;
      loss_cnt_ff <= 5'h00;
    end else if (want == loss_ff) begin
      loss_cnt_ff <= 5'h00;
    end else if (loss_cnt_ff == LOSS_CYC[4:0] - 5'h01) begin
      loss_ff     <= want;
      loss_cnt_ff <= 5'h00;
    end else begin
      loss_cnt_ff <= loss_cnt_ff + 5'h01;
    end
  end

  // ****************************************************************
  // status pins
  // ****************************************************************
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      lock_lost_flag_o   <= 1'b1;
      signal_loss_flag_o <= 1'b0;
    end else begin
      lock_lost_flag_o   <= lsc_ctrl_ff[`LSC_STICKY_SEL] ?
                            sticky_ff : lol_event;
      signal_loss_flag_o <= loss_ff ^ out_ctrl_ff[`OUT_LOSS_POL];
    end
  end

  // ****************************************************************
  // squelch gating of recovered clock and data
  // ****************************************************************
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      recovered_clock_out_o <= 1'b0;
      recovered_data_out_o  <= 1'b0;
    end else if (!out_ctrl_ff[`OUT_SQ_MODE]) begin
      recovered_clock_out_o <= rec_clk_i & ~squelch_s;
      recovered_data_out_o  <= rec_data_i & ~squelch_s;
    end else begin
      recovered_clock_out_o <= rec_clk_i & squelch_s;
      recovered_data_out_o  <= rec_data_i & ~squelch_s;
    end
  end

endmodule

// ****************************************************************
// two-flop synchroniser for inputs from outside the clock domain
// ****************************************************************
module sync_2ff #(
  parameter W = 1
) (
  // clock
  input  wire         clk_i,
  // asynchronous input and its synchronised copy
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);

  reg [W-1:0] meta_ff;

  // only the second flop is read by logic
  always @(posedge clk_i) begin
    meta_ff <= d_i;
    q_o     <= meta_ff;
  end

endmodule

// [include/cdr_lock_defs.vh]
// register offsets, field positions, reset values and timing counts
`ifndef CDR_LOCK_DEFS_VH
`define CDR_LOCK_DEFS_VH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define ADDR_REFERENCE_CONTROL   4'h0
`define ADDR_LOCK_STATUS_CONTROL 4'h4
`define ADDR_OUTPUT_CONTROL      4'h8
`define ADDR_STATUS              4'hC

// ****************************************************************
// field positions
// ****************************************************************
`define REF_LOCK_BIT     0
`define REF_FINE_BIT     1
`define REF_RATIO_LSB    2
`define REF_RATIO_MSB    5
`define REF_RANGE_LSB    6
`define REF_RANGE_MSB    7
`define LSC_STICKY_CLR   6
`define LSC_STICKY_SEL   7
`define OUT_SQ_MODE      1
`define OUT_LOSS_POL     2
`define STAT_STICKY_BIT  4

// ****************************************************************
// reset values
// ****************************************************************
`define RST_REFERENCE_CONTROL   8'h00
`define RST_LOCK_STATUS_CONTROL 8'h00
`define RST_OUTPUT_CONTROL      8'h00

// ****************************************************************
// frequency error limits (ppm) and timing
// ****************************************************************
`define PPM_LOCK_IN      250
`define PPM_LOCK_OUT     1000
`define LOSS_RESP_NS     500
`define CLK_PERIOD_NS    50
`define HARM_BIT_PERIODS 16384
`define TUNE_BOTTOM      16'h0000
`define TUNE_STEP_MAX    16'h0400

`endif

// [test/framer_model.sv]
// downstream framer model: counts rising edges of the recovered clock
`timescale 1ns/100ps
module framer_model (
  // clock and reset
  input  wire         ref_clk_i,
  input  wire         srst_i,
  // gated recovered clock
  input  wire         clk_out_i,
  output logic [15:0] edges_o
);
  logic last_ff;

  always @(posedge ref_clk_i) begin
    last_ff <= clk_out_i;
    if (srst_i)
      edges_o <= 16'h0000;
    else if (clk_out_i && !last_ff)
      edges_o <= edges_o + 16'h0001;
  end
endmodule

// [test/cdr_lock_chk.sv]
// checker for lock, signal-loss and squelch pins
`timescale 1ns/100ps
`include "cdr_lock_defs.vh"
module cdr_lock_chk #(
  parameter ERR_W = 16
) (
  // clock, reset and register writes
  input wire             ref_clk_i,
  input wire             srst_i,
  input wire [3:0]       addr_i,
  input wire [7:0]       wdata_i,
  input wire             wr_i,
  // measurement inputs
  input wire [ERR_W-1:0] data_ppm_err_i,
  input wire             level_below_thr_i,
  input wire             level_above_2thr_i,
  input wire             squelch_i,
  // watched outputs
  input wire [15:0]      vco_tune_o,
  input wire             freq_loop_en_o,
  input wire             use_reference_o,
  input wire             lock_lost_flag_o,
  input wire             signal_loss_flag_o,
  input wire             recovered_clock_out_o,
  input wire             recovered_data_out_o
);
  reg mode_ff, pol_ff, sel_ff;

  // shadow of the control bits that steer the pins
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      mode_ff <= 1'b0;
      pol_ff  <= 1'b0;
      sel_ff  <= 1'b0;
    end else if (wr_i && addr_i == `ADDR_OUTPUT_CONTROL) begin
      mode_ff <= wdata_i[`OUT_SQ_MODE];
      pol_ff  <= wdata_i[`OUT_LOSS_POL];
    end else if (wr_i && addr_i == `ADDR_LOCK_STATUS_CONTROL) begin
      sel_ff <= wdata_i[`LSC_STICKY_SEL];
    end
  end

  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);

  chk_err_relock: assert property (
    (data_ppm_err_i > `PPM_LOCK_OUT && !use_reference_o) [*6]
    |-> freq_loop_en_o) else $error("no acquisition on large error");
  chk_tune_bottom: assert property (
    $rose(freq_loop_en_o) && !use_reference_o |-> ##[0:2]
    vco_tune_o == `TUNE_BOTTOM) else $error("tuning not at bottom");
  chk_loss_resp: assert property (
    $rose(level_below_thr_i) && !level_above_2thr_i |-> ##[1:20]
    signal_loss_flag_o != pol_ff) else $error("signal loss too slow");
  chk_pol_flip: assert property (
    $changed(pol_ff) |-> ##[0:3] $changed(signal_loss_flag_o))
    else $error("polarity change not seen");
  chk_pin_live: assert property (
    $rose(freq_loop_en_o) && !sel_ff |-> ##[0:2] lock_lost_flag_o)
    else $error("lock lost pin not raised");
  chk_sq_both: assert property (
    (squelch_i && !mode_ff) [*4] |-> !recovered_clock_out_o &&
    !recovered_data_out_o) else $error("outputs not squelched");
  chk_sq_data: assert property (
    (squelch_i && mode_ff) [*4] |-> !recovered_data_out_o)
    else $error("data not squelched");
  chk_sq_clock: assert property (
    (!squelch_i && mode_ff) [*4] |-> !recovered_clock_out_o)
    else $error("clock not squelched");

  cover property ($rose(lock_lost_flag_o));
  cover property ($fell(signal_loss_flag_o));
  cover property (squelch_i && mode_ff);
endmodule

// [test/tb.sv]
// self-checking bench for lock supervision, signal loss and squelch
`timescale 1ns/100ps
`include "cdr_lock_defs.vh"
module tb;
  logic        ref_clk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic [3:0]  addr_i = 4'h0;
  logic [7:0]  wdata_i = 8'h00;
  logic [15:0] data_ppm_err_i = 16'h1000, ref_ppm_err_i = 16'h00C8;
  logic        data_freq_above_i = 1'b0, level_below_thr_i = 1'b0;
  logic        level_above_2thr_i = 1'b0, lower_harmonic_i = 1'b0;
  logic        bit_tick_i = 1'b0, squelch_i = 1'b0;
  logic        rec_clk_i = 1'b0, rec_data_i = 1'b0;
  wire  [7:0]  rdata_o;
  wire  [15:0] vco_tune_o, edges;
  wire  [3:0]  ratio_o;
  wire  [1:0]  range_o;
  wire         freq_loop_en_o, use_reference_o, lock_lost_flag_o;
  wire         signal_loss_flag_o, recovered_clock_out_o;
  wire         recovered_data_out_o;
  int          num_errors = 0, checks = 0;
  logic [15:0] e;

  cdr_lock_status_squelch #(.HARM_CNT(8)) i_dut (.*);
  framer_model i_far (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .clk_out_i(recovered_clock_out_o), .edges_o(edges));

  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) rec_clk_i <= ~rec_clk_i;

  task automatic chk(input string n, input logic [15:0] x, g);
    checks++;
    if (g !== x) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] x);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    cyc(1);
    rd_i <= 1'b0;
    chk("rdata", {8'h00, x}, {8'h00, rdata_o});
  endtask
  task automatic wait_lol(input logic v);
    int n;
    n = 0;
    while (lock_lost_flag_o !== v && n < 300) begin
      cyc(1);
      n++;
    end
    chk("lock_lost", {15'h0, v}, {15'h0, lock_lost_flag_o});
    if (n == 300)
      finish_test();
  endtask
  task automatic ticks();
    repeat (8) begin
      @(posedge ref_clk_i);
      bit_tick_i <= 1'b1;
      @(posedge ref_clk_i);
      bit_tick_i <= 1'b0;
    end
  endtask
  task automatic set_err(input logic [15:0] d, r);
    @(posedge ref_clk_i);
    data_ppm_err_i <= d;
    ref_ppm_err_i  <= r;
  endtask

  task automatic t_reset_lock();
    chk("lock_lost", 16'h1, {15'h0, lock_lost_flag_o});
    chk("vco_tune", `TUNE_BOTTOM, vco_tune_o);
    chk("loss", 16'h0, {15'h0, signal_loss_flag_o});
    @(posedge ref_clk_i);
    data_freq_above_i <= 1'b1;
    rd(`ADDR_OUTPUT_CONTROL, `RST_OUTPUT_CONTROL);
    rd(`ADDR_REFERENCE_CONTROL, `RST_REFERENCE_CONTROL);
    rd(4'h2, 8'h00);
    rd(`ADDR_STATUS, 8'h11);
    cyc(20);
    chk("tune_up", 16'h1, {15'h0, vco_tune_o != `TUNE_BOTTOM});
    set_err(16'h00C8, 16'h00C8);
    wait_lol(1'b0);
    chk("freq_loop", 16'h0, {15'h0, freq_loop_en_o});
    set_err(16'h04B0, 16'h00C8);
    wait_lol(1'b1);
    set_err(16'h00C8, 16'h00C8);
    wait_lol(1'b0);
    $display("test reset and lock done");
  endtask
  task automatic t_sticky();
    wr(`ADDR_LOCK_STATUS_CONTROL, 8'h40);
    wr(`ADDR_LOCK_STATUS_CONTROL, 8'h00);
    rd(`ADDR_STATUS, 8'h00);
    wr(`ADDR_LOCK_STATUS_CONTROL, 8'h80);
    cyc(2);
    chk("lock_lost", 16'h0, {15'h0, lock_lost_flag_o});
    set_err(16'h04B0, 16'h00C8);
    wait_lol(1'b1);
    set_err(16'h00C8, 16'h00C8);
    wr(`ADDR_LOCK_STATUS_CONTROL, 8'h00);
    wait_lol(1'b0);
    wr(`ADDR_LOCK_STATUS_CONTROL, 8'h80);
    cyc(2);
    chk("lock_lost", 16'h1, {15'h0, lock_lost_flag_o});
    wr(`ADDR_LOCK_STATUS_CONTROL, 8'h00);
    $display("test sticky done");
  endtask
  task automatic t_loss();
    @(posedge ref_clk_i);
    level_below_thr_i <= 1'b1;
    cyc(16);
    chk("loss", 16'h1, {15'h0, signal_loss_flag_o});
    @(posedge ref_clk_i);
    level_below_thr_i <= 1'b0;
    cyc(20);
    chk("loss", 16'h1, {15'h0, signal_loss_flag_o});
    @(posedge ref_clk_i);
    level_above_2thr_i <= 1'b1;
    cyc(16);
    chk("loss", 16'h0, {15'h0, signal_loss_flag_o});
    wr(`ADDR_OUTPUT_CONTROL, 8'h04);
    cyc(3);
    chk("loss", 16'h1, {15'h0, signal_loss_flag_o});
    wr(`ADDR_OUTPUT_CONTROL, 8'h00);
    $display("test signal loss done");
  endtask
  task automatic t_harm();
    @(posedge ref_clk_i);
    lower_harmonic_i <= 1'b1;
    ticks();
    wait_lol(1'b1);
    @(posedge ref_clk_i);
    lower_harmonic_i <= 1'b0;
    wait_lol(1'b0);
    wr(`ADDR_REFERENCE_CONTROL, 8'h95);
    cyc(3);
    wait_lol(1'b0);
    chk("ratio", 16'h0005, {12'h000, ratio_o});
    chk("range", 16'h0002, {14'h0000, range_o});
    chk("use_ref", 16'h1, {15'h0, use_reference_o});
    @(posedge ref_clk_i);
    lower_harmonic_i <= 1'b1;
    ticks();
    cyc(6);
    chk("lock_lost", 16'h0, {15'h0, lock_lost_flag_o});
    lower_harmonic_i <= 1'b0;
    set_err(16'h00C8, 16'h04B0);
    wait_lol(1'b1);
    set_err(16'h00C8, 16'h00C8);
    wait_lol(1'b0);
    wr(`ADDR_REFERENCE_CONTROL, 8'h00);
    $display("test harmonic done");
  endtask
  task automatic t_squelch();
    @(posedge ref_clk_i);
    rec_data_i <= 1'b1;
    squelch_i  <= 1'b1;
    cyc(4);
    e = edges;
    cyc(6);
    chk("edges", e, edges);
    chk("data_out", 16'h0, {15'h0, recovered_data_out_o});
    wr(`ADDR_OUTPUT_CONTROL, 8'h02);
    cyc(4);
    e = edges;
    cyc(6);
    chk("edges_run", 16'h1, {15'h0, edges != e});
    chk("data_out", 16'h0, {15'h0, recovered_data_out_o});
    @(posedge ref_clk_i);
    squelch_i <= 1'b0;
    cyc(4);
    e = edges;
    cyc(6);
    chk("edges", e, edges);
    chk("data_out", 16'h1, {15'h0, recovered_data_out_o});
    $display("test squelch done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    cyc(1);
    t_reset_lock();
    t_sticky();
    t_loss();
    t_harm();
    t_squelch();
    finish_test();
  end
endmodule

bind cdr_lock_status_squelch cdr_lock_chk #(.ERR_W(ERR_W)) i_chk (.*);
